// File: include/pums_pkg.sv
// Purpose: Shared constants and types for the power-up mode sequencer
// Assumes: Single 250 MHz clock, synchronous active-high reset
// Notes:   Times are kept in their printed unit; cycle counts derive from the clock rate
package pums_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned HOLD_MS         = 50;
  localparam int unsigned HOLD_CYCLES     = HOLD_MS * 1000 * CLK_MHZ;
  localparam int unsigned INIT_CYCLES_DEF = 16;
  localparam int unsigned CFG_WORDS_DEF   = 64;

  // ==========================================================================
  // Widths, depths and pin drive values
  // ==========================================================================
  localparam int unsigned CFG_W       = 8;
  localparam int unsigned BUF_DEPTH   = 2;
  localparam logic        UNUSED_HIGH = 1'b0;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    PUMS_MODE_INSTANT,
    PUMS_MODE_DELAYED,
    PUMS_MODE_EMULATE
  } pums_mode_e;

  typedef enum logic [2:0] {
    PUMS_ST_POR,
    PUMS_ST_HOLD,
    PUMS_ST_RECEIVE,
    PUMS_ST_INIT,
    PUMS_ST_READY
  } pums_state_e;

  // Open-drain pin drive: oe high pulls the line low
  typedef struct packed {
    logic o;
    logic oe;
  } pums_od_s;

  typedef struct packed {
    logic [CFG_W-1:0] data;
  } pums_cfg_s;

endpackage : pums_pkg

// File: rtl/pums_skid_buf.sv
// Purpose: Two-entry buffer with valid/ready on both sides
// Assumes: Single clock, synchronous reset
// Notes:   Storage registered; ready drops only when both entries hold words
`timescale 1ns/1ps
module pums_skid_buf #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [$clog2(DEPTH):0] count;
  logic [$clog2(DEPTH)-1:0] wr_ptr;
  logic [$clog2(DEPTH)-1:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready_o  = (count != DEPTH[$clog2(DEPTH):0]);
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      count  <= '0;
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == $clog2(DEPTH)'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == $clog2(DEPTH)'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + {{$clog2(DEPTH){1'b0}}, push} - {{$clog2(DEPTH){1'b0}}, pop};
    end
  end

endmodule : pums_skid_buf

// File: rtl/pums_sequencer.sv
// Purpose: Power-up readiness sequencer with instant, delayed and emulation modes
// Assumes: srst_i is the power-on reset; inputs synchronous to clk_i
// Notes:   Bitstream content is counted, not interpreted
`timescale 1ns/1ps
module pums_sequencer
  import pums_pkg::*;
#(
  parameter pums_mode_e  MODE          = PUMS_MODE_INSTANT,
  parameter bit          HAS_EMULATION = 1'b1,
  parameter bit          USE_INIT_PIN  = 1'b1,
  parameter logic        UNUSED_DRIVE  = UNUSED_HIGH,
  parameter int unsigned HOLD_COUNT    = HOLD_CYCLES,
  parameter int unsigned INIT_COUNT    = INIT_CYCLES_DEF,
  parameter int unsigned CFG_WORDS     = CFG_WORDS_DEF
) (
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  input  wire logic                cfg_valid_i,
  output logic                     cfg_ready_o,
  input  wire pums_pkg::pums_cfg_s cfg_word_i,
  output pums_pkg::pums_od_s       config_complete_line_o,
  output pums_pkg::pums_od_s       init_complete_line_o,
  output logic                     user_reset_o,
  output logic                     user_ready_o,
  output logic                     cfg_error_o,
  output logic                     unused_pin_o,
  output logic                     unused_pin_oe_o
);
  import pums_pkg::*;

  // ==========================================================================
  // Mode capture
  // ==========================================================================
  pums_mode_e  mode;
  pums_state_e state;
  logic [31:0] hold_cnt;
  logic [31:0] init_cnt;
  logic [31:0] word_cnt;
  logic        buf_valid;
  logic        buf_ready;
  pums_cfg_s   buf_word;
  logic        in_ready;

  // Latched while reset is high only, so a build choice cannot shift mid-run
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      // Variants without emulation that are built for emulate mode fall back to instant mode
      if (MODE == PUMS_MODE_EMULATE && !HAS_EMULATION) begin
        mode <= PUMS_MODE_INSTANT;
      end else begin
        mode <= MODE;
      end
    end
  end

  // ==========================================================================
  // Bitstream buffer
  // ==========================================================================
  pums_skid_buf #(
    .WIDTH (CFG_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (cfg_valid_i && state == PUMS_ST_RECEIVE),
    .in_ready_o  (in_ready),
    .in_data_i   (cfg_word_i.data),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_ready),
    .out_data_o  (buf_word.data)
  );

  // Words drain one per cycle while receiving; flushed otherwise
  assign buf_ready = 1'b1;

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state    <= PUMS_ST_POR;
      hold_cnt <= '0;
      init_cnt <= '0;
      word_cnt <= '0;
    end else begin
      unique case (state)
        PUMS_ST_POR: begin
          // Readiness modes need no data from outside
          unique case (mode)
            PUMS_MODE_DELAYED: state <= PUMS_ST_HOLD;
            PUMS_MODE_EMULATE: state <= PUMS_ST_RECEIVE;
            default:           state <= PUMS_ST_READY;
          endcase
        end
        PUMS_ST_HOLD: begin
          if (hold_cnt == HOLD_COUNT - 1) begin
            state <= PUMS_ST_READY;
          end else begin
            hold_cnt <= hold_cnt + 32'h1;
          end
        end
        PUMS_ST_RECEIVE: begin
          if (buf_valid) begin
            if (word_cnt == CFG_WORDS - 1) begin
              state <= PUMS_ST_INIT;
            end
            word_cnt <= word_cnt + 32'h1;
          end
        end
        PUMS_ST_INIT: begin
          if (init_cnt == INIT_COUNT - 1) begin
            state <= PUMS_ST_READY;
          end else begin
            init_cnt <= init_cnt + 32'h1;
          end
        end
        PUMS_ST_READY: state <= PUMS_ST_READY;
      endcase
    end
  end

  // ==========================================================================
  // Pins
  // ==========================================================================
  // Reset keeps every driver off; the completion line is held low afterwards
  // only in the power-on phase of non-instant modes and in the hold and receive phases
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      config_complete_line_o <= '{o: 1'b0, oe: 1'b0};
      init_complete_line_o   <= '{o: 1'b0, oe: 1'b0};
      unused_pin_o           <= 1'b0;
      unused_pin_oe_o        <= 1'b0;
    end else begin
      config_complete_line_o.o  <= 1'b0;
      config_complete_line_o.oe <= (state == PUMS_ST_HOLD && hold_cnt != HOLD_COUNT - 1)
                                   || (state == PUMS_ST_RECEIVE)
                                   || (state == PUMS_ST_POR && mode != PUMS_MODE_INSTANT);
      init_complete_line_o.o    <= 1'b0;
      init_complete_line_o.oe   <= USE_INIT_PIN && mode == PUMS_MODE_EMULATE
                                   && state != PUMS_ST_READY;
      // Tristated pin reads as ground through the board; driven pin goes high
      unused_pin_o              <= UNUSED_DRIVE;
      unused_pin_oe_o           <= UNUSED_DRIVE;
    end
  end

  // ==========================================================================
  // User-side status
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      user_reset_o <= 1'b1;
      user_ready_o <= 1'b0;
      cfg_error_o  <= 1'b0;
      cfg_ready_o  <= 1'b0;
    end else begin
      user_reset_o <= (state != PUMS_ST_READY);
      user_ready_o <= (state == PUMS_ST_READY);
      cfg_ready_o  <= in_ready && (state == PUMS_ST_POR ? mode == PUMS_MODE_EMULATE
                                                        : state == PUMS_ST_RECEIVE);
      // Words offered outside the receive and power-on phases are dropped and flagged
      if (cfg_valid_i && state != PUMS_ST_RECEIVE && state != PUMS_ST_POR) begin
        cfg_error_o <= 1'b1;
      end
    end
  end

endmodule : pums_sequencer

// File: test/pums_checker.sv
// Purpose: Port assertions for the sequencer
// Assumes: Bound to every sequencer instance
// Notes:   Mode comes from the instance; variants without emulation are checked as instant
`timescale 1ns/1ps
module pums_checker
  import pums_pkg::*;
#(
  parameter pums_mode_e  MODE = PUMS_MODE_INSTANT,
  parameter int unsigned HOLD = 20
) (
  input wire logic               clk_i,
  input wire logic               srst_i,
  input wire pums_pkg::pums_od_s config_complete_line_o,
  input wire pums_pkg::pums_od_s init_complete_line_o,
  input wire logic               user_reset_o,
  input wire logic               user_ready_o,
  input wire logic               cfg_error_o
);
  // ==========
  // Hold length
  int unsigned held;
  always_ff @(posedge clk_i) begin
    if (srst_i || !config_complete_line_o.oe) held <= '0;
    else held <= held + 1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_reset_quiet: assert property (disable iff (1'h0) srst_i |=> user_reset_o && !user_ready_o
    && !config_complete_line_o.oe && !init_complete_line_o.oe && !cfg_error_o) else $error("reset state");
  a_ready_gated: assert property (user_ready_o |-> !user_reset_o && !config_complete_line_o.oe
    && !init_complete_line_o.oe) else $error("ready while held");
  a_ready_sticky: assert property (user_ready_o |=> user_ready_o) else $error("ready lost");
  a_instant_open: assert property (MODE == PUMS_MODE_INSTANT |-> !config_complete_line_o.oe)
    else $error("instant line low");
  a_instant_up: assert property ($fell(srst_i) && MODE == PUMS_MODE_INSTANT |-> ##[1:3] user_ready_o)
    else $error("instant late");
  a_hold_span: assert property ($fell(config_complete_line_o.oe) && MODE == PUMS_MODE_DELAYED
    |-> held == HOLD) else $error("hold length");
  a_hold_reset: assert property (config_complete_line_o.oe && MODE == PUMS_MODE_DELAYED |-> user_reset_o)
    else $error("hold not in reset");
  a_error_sticky: assert property (cfg_error_o |=> cfg_error_o) else $error("error lost");
  c_ready: cover property ($rose(user_ready_o));
  c_hold: cover property ($fell(config_complete_line_o.oe));
  c_error: cover property ($rose(cfg_error_o));
endmodule : pums_checker
bind pums_sequencer pums_checker #(
  .MODE(HAS_EMULATION ? MODE : pums_pkg::PUMS_MODE_INSTANT), .HOLD(HOLD_COUNT)) chk (
  .clk_i(clk_i), .srst_i(srst_i), .config_complete_line_o(config_complete_line_o),
  .init_complete_line_o(init_complete_line_o), .user_reset_o(user_reset_o),
  .user_ready_o(user_ready_o), .cfg_error_o(cfg_error_o));

// File: test/pums_host.sv
// Purpose: Behavioural configuration host
// Assumes: A word is taken on valid and ready at an edge
// Notes:   Slow mode idles a cycle after each word
`timescale 1ns/1ps
module pums_host
  import pums_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic           srst_i,
  input  wire logic           go_i,
  input  wire logic           slow_i,
  input  wire logic [7:0]     count_i,
  input  wire logic           cfg_ready_i,
  output logic                cfg_valid_o,
  output pums_pkg::pums_cfg_s cfg_word_o,
  output logic [7:0]          sent_o
);
  logic [7:0] done;
  logic       nv;
  always @(posedge clk_i) begin
    done = sent_o + 8'(cfg_valid_o && cfg_ready_i);
    if (srst_i || !go_i) done = 8'h00;
    // Hold the word until taken; idle data toggles so it never looks valid
    nv = go_i && !srst_i && done < count_i && !(slow_i && cfg_valid_o && cfg_ready_i);
    sent_o      <= done;
    cfg_valid_o <= nv;
    cfg_word_o  <= nv ? done : (srst_i ? 8'h5a : ~cfg_word_o);
  end
endmodule : pums_host

// File: test/test_power_up_mode_sequencer.sv
// Purpose: Self-checking bench for the sequencer
// Assumes: Hold cut to 20 cycles, four words, init of 5
// Notes:   Three instances cover the modes
`timescale 1ns/1ps
module test_power_up_mode_sequencer;
  import pums_pkg::*;
  localparam int unsigned HOLD = 20;
  localparam int unsigned INIT = 5;
  logic       clk_i = 1'h0, srst_i = 1'h1, go = 1'h0, slow = 1'h0;
  logic       rdy, vld, ur, urst, err, unp, unp_oe, ur_d, rst_d, ur_i;
  logic [7:0] sent, cnt = 8'h04;
  pums_cfg_s  word;
  pums_od_s   cc, ic, cc_d, cc_i;
  int         fail_count = 0, comparisons = 0;
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  pums_host host (.clk_i(clk_i), .srst_i(srst_i), .go_i(go), .slow_i(slow), .count_i(cnt),
    .cfg_ready_i(rdy), .cfg_valid_o(vld), .cfg_word_o(word), .sent_o(sent));
  pums_sequencer #(.MODE(PUMS_MODE_EMULATE), .HOLD_COUNT(HOLD), .INIT_COUNT(INIT), .CFG_WORDS(4)) dut (
    .clk_i(clk_i), .srst_i(srst_i), .cfg_valid_i(vld), .cfg_ready_o(rdy), .cfg_word_i(word),
    .config_complete_line_o(cc), .init_complete_line_o(ic), .user_reset_o(urst), .user_ready_o(ur),
    .cfg_error_o(err), .unused_pin_o(unp), .unused_pin_oe_o(unp_oe));
  pums_sequencer #(.MODE(PUMS_MODE_DELAYED), .HOLD_COUNT(HOLD)) dut_d (
    .clk_i(clk_i), .srst_i(srst_i), .cfg_valid_i(1'h0), .cfg_ready_o(), .cfg_word_i(word),
    .config_complete_line_o(cc_d), .init_complete_line_o(), .user_reset_o(rst_d), .user_ready_o(ur_d),
    .cfg_error_o(), .unused_pin_o(), .unused_pin_oe_o());
  pums_sequencer #(.MODE(PUMS_MODE_EMULATE), .HAS_EMULATION(1'h0)) dut_i (
    .clk_i(clk_i), .srst_i(srst_i), .cfg_valid_i(1'h0), .cfg_ready_o(), .cfg_word_i(word),
    .config_complete_line_o(cc_i), .init_complete_line_o(), .user_reset_o(), .user_ready_o(ur_i),
    .cfg_error_o(), .unused_pin_o(), .unused_pin_oe_o());
  // ==========
  // Tasks
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic summarize;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic do_reset;
    srst_i = 1'h1;
    tick(2);
    check("reset held", urst, 1'h1);
    check("reset lines", {cc.oe, ic.oe, ur, err, rdy}, 5'h00);
    srst_i = 1'h0;
  endtask : do_reset
  task automatic t_ready_modes;
    int held;
    held = 0;
    repeat (HOLD + 8) begin
      if (cc_d.oe === 1'h1) begin
        held++;
        check("held in reset", rst_d, 1'h1);
      end
      tick();
    end
    check("hold cycles", held, HOLD);
    check("delayed ready", {ur_d, rst_d, cc_d.oe}, 3'h4);
    check("instant ready", {ur_i, cc_i.oe}, 2'h2);
  endtask : t_ready_modes
  task automatic t_emulate(input logic slow_mode);
    int n;
    int last;
    slow = slow_mode;
    go = 1'h1;
    tick(2);
    check("waiting", {ur, cc.oe, ic.oe}, 3'h3);
    n = 0;
    last = 0;
    while (ur !== 1'h1 && n < 200) begin
      if (sent !== 8'h04) last = n;
      tick();
      n++;
    end
    check("words taken", sent, 8'h04);
    check("ready lines", {ur, urst, cc.oe, ic.oe, err}, 5'h10);
    // Pull-up model: a released line reads high, which the host takes as ready
    check("line pulled up", cc.oe ? cc.o : 1'h1, 1'h1);
    // One edge to take the last word, one to drain it, the init span, then one edge to show ready
    check("init phase", n - last, INIT + 3);
    go = 1'h0;
  endtask : t_emulate
  task automatic t_refuse;
    cnt = 8'h01;
    tick();
    go = 1'h1;
    tick(4);
    check("refused word", {err, rdy, ur}, 3'h5);
    go = 1'h0;
    cnt = 8'h04;
  endtask : t_refuse
  initial begin
    do_reset();
    t_ready_modes();
    t_emulate(1'h0);
    t_refuse();
    check("unused pin", {unp, unp_oe}, {UNUSED_HIGH, UNUSED_HIGH});
    do_reset();
    t_emulate(1'h1);
    summarize();
  end
  // Far beyond the few hundred nanoseconds the sequence needs
  initial begin
    #20000;
    fail_count++;
    summarize();
  end
endmodule : test_power_up_mode_sequencer
